// File: rtl/voltage_adc_sequencer.sv
`timescale 1ns/1ps
`include "adc_seq_map.svh"

module voltage_adc_sequencer #(
  parameter int CONV_CYCLES =
    (`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int TIMEOUT_CYCLES =
    (`TIMEOUT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic smb_activity_in,
  output logic bus_release_out,
  input wire logic [9:0] adc_code_in,
  output logic adc_start_out,
  output adc_seq_pkg::adc_chan_t adc_chan_out,
  output logic atten_bypass_out,
  input wire logic status_clear_in,
  input wire logic alert_enable_in,
  output logic low_status_out,
  output logic high_status_out,
  output logic smb_alert_n_out
);
  import adc_seq_pkg::*;

  localparam logic [15:0] CONV_LOAD = 16'(CONV_CYCLES - `CONV_OVERHEAD);
  localparam logic [20:0] TMO_LAST = 21'(TIMEOUT_CYCLES - 1);

  localparam seq_state_t RST = '{
    state: ST_START,
    timer: 16'h0000,
    chan: `CH_CHIPSET,
    tmo_cnt: 21'h000000,
    cfg1: `RST_CFG1,
    cfg2: `RST_CFG2,
    fan1_min_hi: `RST_FAN1_MIN_HI,
    cs_low_lim: `RST_CS_LOW,
    cs_high_lim: `RST_CS_HIGH,
    cs_reading: `RST_READING,
    own_reading: `RST_READING,
    rdata: `RD_UNMAPPED,
    st_low: 1'b0,
    st_high: 1'b0,
    alert_n: 1'b1,
    start: 1'b0,
    sample: 1'b0,
    release_p: 1'b0,
    bypass: 1'b0
  };

  seq_state_t r;
  seq_state_t n;
  logic acc_valid;
  logic [9:0] acc_result;
  logic [7:0] top8;
  logic single_mode;

  // Full 10-bit code kept through averaging
  adc_average u_avg (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .sample_in(r.sample),
    .code_in(adc_code_in),
    .avg_off_in(r.cfg2[`CFG2_AVG_OFF_BIT]),
    .result_valid_out(acc_valid),
    .result_out(acc_result)
  );

  assign top8 = acc_result[`CODE_MSB:`CODE_TOP8_LSB];
  assign single_mode = r.cfg2[`CFG2_SINGLE_BIT];

  function automatic adc_chan_t next_chan(input adc_chan_t c);
    case (c)
      `CH_CHIPSET: next_chan = `CH_OWN;
      `CH_OWN: next_chan = `CH_REMOTE1;
      `CH_REMOTE1: next_chan = `CH_LOCAL;
      `CH_LOCAL: next_chan = `CH_REMOTE2;
      default: next_chan = `CH_CHIPSET;
    endcase
  endfunction

  always_comb begin
    n = r;
    n.start = 1'b0;
    n.sample = 1'b0;
    n.release_p = 1'b0;

    if (r.cfg1[`CFG1_TMO_DIS_BIT] || smb_activity_in) begin
      n.tmo_cnt = '0;
    end else if (r.tmo_cnt == TMO_LAST) begin
      n.tmo_cnt = '0;
      n.release_p = 1'b1;
    end else begin
      n.tmo_cnt = r.tmo_cnt + 21'h000001;
    end

    if (reg_wr_in) begin
      case (reg_addr_in)
        `OFS_CFG1: n.cfg1 = reg_wdata_in;
        `OFS_CS_LOW: n.cs_low_lim = reg_wdata_in;
        `OFS_CS_HIGH: n.cs_high_lim = reg_wdata_in;
        `OFS_FAN1_MIN_HI: n.fan1_min_hi = reg_wdata_in;
        `OFS_CFG2: n.cfg2 = reg_wdata_in;
        default: ;
      endcase
    end

    // Readings are read-only; writes to them fall through
    if (reg_rd_in) begin
      case (reg_addr_in)
        `OFS_CS_READING: n.rdata = r.cs_reading;
        `OFS_OWN_READING: n.rdata = r.own_reading;
        `OFS_CFG1: n.rdata = r.cfg1;
        `OFS_CS_LOW: n.rdata = r.cs_low_lim;
        `OFS_CS_HIGH: n.rdata = r.cs_high_lim;
        `OFS_FAN1_MIN_HI: n.rdata = r.fan1_min_hi;
        `OFS_CFG2: n.rdata = r.cfg2;
        default: n.rdata = `RD_UNMAPPED;
      endcase
    end

    n.bypass = r.cfg2[`CFG2_BYPASS_BIT];

    // Clear first so a same-cycle violation still sets
    if (status_clear_in) begin
      n.st_low = 1'b0;
      n.st_high = 1'b0;
    end

    case (r.state)
      ST_START: begin
        // Averager result lands one cycle after the sample, i.e. here
        if (acc_valid) begin
          if (r.chan == `CH_CHIPSET) begin
            n.cs_reading = top8;
            if (top8 > r.cs_high_lim) begin
              n.st_high = 1'b1;
            end
            if (top8 < r.cs_low_lim) begin
              n.st_low = 1'b1;
            end
          end else if (r.chan == `CH_OWN) begin
            n.own_reading = top8;
          end
          if (!single_mode) begin
            n.chan = next_chan(r.chan);
          end
        end
        // Single mode channel from select field
        if (single_mode) begin
          n.chan = r.fan1_min_hi[`CHAN_SEL_MSB:`CHAN_SEL_LSB];
        end
        // One shared converter started per channel
        n.start = 1'b1;
        n.timer = CONV_LOAD;
        n.state = ST_CONV;
      end
      ST_CONV: begin
        if (r.timer == 16'h0000) begin
          n.sample = 1'b1;
          n.state = ST_WAIT;
        end else begin
          n.timer = r.timer - 16'h0001;
        end
      end
      ST_WAIT: begin
        n.state = ST_START;
      end
      default: n.state = ST_START;
    endcase

    n.alert_n = !((n.st_low || n.st_high) && alert_enable_in);
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  assign reg_rdata_out = r.rdata;
  assign bus_release_out = r.release_p;
  assign adc_start_out = r.start;
  assign adc_chan_out = r.chan;
  assign atten_bypass_out = r.bypass;
  assign low_status_out = r.st_low;
  assign high_status_out = r.st_high;
  assign smb_alert_n_out = r.alert_n;

  // Cycles since last start, for period checks only
  logic [15:0] since_start;
  logic seen_start;
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      since_start <= 16'h0000;
      seen_start <= 1'b0;
    end else if (adc_start_out) begin
      since_start <= 16'h0001;
      seen_start <= 1'b1;
    end else begin
      since_start <= since_start + 16'h0001;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  conv_period_a: assert property (
    adc_start_out && seen_start |-> since_start == 16'(CONV_CYCLES)
  ) else $error("conversion period wrong");

  reset_values_a: assert property (
    disable iff (1'b0) $past(sys_rst_in) |->
      r.cs_low_lim == `RST_CS_LOW && r.cs_high_lim == `RST_CS_HIGH &&
      r.cs_reading == `RST_READING && r.own_reading == `RST_READING &&
      !r.cfg1[`CFG1_TMO_DIS_BIT]
  ) else $error("register reset value wrong");

  tmo_disabled_a: assert property (
    r.cfg1[`CFG1_TMO_DIS_BIT] |=> !bus_release_out
  ) else $error("release while timeout disabled");

  tmo_activity_a: assert property (
    smb_activity_in |=> !bus_release_out ##1 !bus_release_out
  ) else $error("release right after bus activity");

  high_limit_a: assert property (
    r.state == ST_START && acc_valid && r.chan == `CH_CHIPSET &&
      top8 > r.cs_high_lim |=> high_status_out && r.cs_reading == $past(top8)
  ) else $error("high limit status missed");

  low_limit_a: assert property (
    r.state == ST_START && acc_valid && r.chan == `CH_CHIPSET &&
      top8 < r.cs_low_lim |=> low_status_out
  ) else $error("low limit status missed");

  alert_drive_a: assert property (
    (low_status_out || high_status_out) && $past(alert_enable_in) |->
      !smb_alert_n_out
  ) else $error("alert not driven on violation");

  single_chan_a: assert property (
    adc_start_out && $past(single_mode) |->
      adc_chan_out == $past(r.fan1_min_hi[`CHAN_SEL_MSB:`CHAN_SEL_LSB])
  ) else $error("single mode channel wrong");

  bypass_a: assert property (
    $changed(atten_bypass_out) |->
      $past(r.cfg2[`CFG2_BYPASS_BIT]) == atten_bypass_out
  ) else $error("bypass does not follow config");

  reading_src_a: assert property (
    $changed(r.cs_reading) |-> $past(acc_valid) &&
      $past(r.chan) == `CH_CHIPSET
  ) else $error("chipset reading changed without result");

  own_store_a: assert property (
    r.state == ST_START && acc_valid && r.chan == `CH_OWN |=>
      r.own_reading == $past(top8)
  ) else $error("own supply reading not stored");

  status_sticky_a: assert property (
    high_status_out && !status_clear_in |=> high_status_out
  ) else $error("high status dropped without clear");

  cov_store: cover property (
    r.state == ST_START && acc_valid && r.chan == `CH_CHIPSET);
  cov_single: cover property (adc_start_out && single_mode);
  cov_release: cover property (bus_release_out);
  cov_alert: cover property ($fell(smb_alert_n_out));
endmodule

// File: rtl/adc_seq_map.svh
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

// Register offsets
`define OFS_CS_READING 8'h21
`define OFS_OWN_READING 8'h22
`define OFS_CFG1 8'h40
`define OFS_CS_LOW 8'h46
`define OFS_CS_HIGH 8'h47
`define OFS_FAN1_MIN_HI 8'h55
`define OFS_CFG2 8'h73

// Reset values
`define RST_READING 8'h00
`define RST_CFG1 8'h00
`define RST_CS_LOW 8'h00
`define RST_CS_HIGH 8'hFF
`define RST_FAN1_MIN_HI 8'h00
`define RST_CFG2 8'h00
`define RD_UNMAPPED 8'h00

// Field positions
`define CFG1_TMO_DIS_BIT 6
`define CFG2_AVG_OFF_BIT 4
`define CFG2_BYPASS_BIT 5
`define CFG2_SINGLE_BIT 6
`define CHAN_SEL_MSB 7
`define CHAN_SEL_LSB 5
`define CODE_MSB 9
`define CODE_TOP8_LSB 2

// Channel codes
`define CH_CHIPSET 3'h1
`define CH_OWN 3'h2
`define CH_REMOTE1 3'h5
`define CH_LOCAL 3'h6
`define CH_REMOTE2 3'h7

// Averaging
`define AVG_LAST 4'hF
`define AVG_SHIFT 4

// Timing
`define CLK_PERIOD_NS 25
`define CONV_TIME_NS 711000
`define TIMEOUT_TIME_NS 35000000
`define CONV_OVERHEAD 3

`endif

// File: rtl/adc_seq_pkg.sv
package adc_seq_pkg;
  typedef logic [2:0] adc_chan_t;

  typedef enum logic [1:0] {
    ST_START = 2'b00,
    ST_CONV = 2'b01,
    ST_WAIT = 2'b10
  } seq_fsm_t;

  typedef struct packed {
    seq_fsm_t state;
    logic [15:0] timer;
    adc_chan_t chan;
    logic [20:0] tmo_cnt;
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [7:0] fan1_min_hi;
    logic [7:0] cs_low_lim;
    logic [7:0] cs_high_lim;
    logic [7:0] cs_reading;
    logic [7:0] own_reading;
    logic [7:0] rdata;
    logic st_low;
    logic st_high;
    logic alert_n;
    logic start;
    logic sample;
    logic release_p;
    logic bypass;
  } seq_state_t;

  typedef struct packed {
    logic [13:0] sum;
    logic [3:0] cnt;
    logic valid;
    logic [9:0] result;
  } avg_state_t;
endpackage

// File: rtl/adc_average.sv
`timescale 1ns/1ps
`include "adc_seq_map.svh"

module adc_average (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic sample_in,
  input wire logic [9:0] code_in,
  input wire logic avg_off_in,
  output logic result_valid_out,
  output logic [9:0] result_out
);
  import adc_seq_pkg::*;

  avg_state_t r;
  avg_state_t n;
  logic [13:0] total;

  assign total = r.sum + {4'h0, code_in};

  always_comb begin
    n = r;
    n.valid = 1'b0;
    if (sample_in) begin
      if (avg_off_in) begin
        n.result = code_in;
        n.valid = 1'b1;
        n.sum = '0;
        n.cnt = '0;
      end else if (r.cnt == `AVG_LAST) begin
        n.result = total[13:`AVG_SHIFT];
        n.valid = 1'b1;
        n.sum = '0;
        n.cnt = '0;
      end else begin
        n.sum = total;
        n.cnt = r.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign result_valid_out = r.valid;
  assign result_out = r.result;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  avg_off_pass_a: assert property (
    sample_in && avg_off_in |=> result_valid_out && result_out == $past(code_in)
  ) else $error("single conversion not passed through");

  avg_mean_a: assert property (
    sample_in && !avg_off_in && r.cnt != `AVG_LAST |=> !result_valid_out
  ) else $error("average released before sixteen samples");
endmodule

// File: bench/adc_conv_model.sv
`timescale 1ns/1ps
module adc_conv_model #(
  parameter int CONV_CYCLES = 8
) (
  input wire logic ref_clk_in,
  input wire logic start_in,
  input wire logic [2:0] chan_in,
  input wire logic [9:0] cs_code_in,
  input wire logic [9:0] own_code_in,
  output logic [9:0] code_out
);
  int cnt = 0;
  logic [9:0] val = 10'h000;
  always @(posedge ref_clk_in) begin
    if (start_in) begin
      cnt <= 1;
      val <= (chan_in == 3'h2) ? own_code_in : cs_code_in;
    end else if (cnt != 0 && cnt < CONV_CYCLES - 1) begin
      cnt <= cnt + 1;
    end else begin
      cnt <= 0;
    end
  end
  // Outside a conversion the code is not trustworthy
  assign code_out = (cnt != 0) ? val : ~val;
endmodule

// File: bench/voltage_adc_sequencer_tb_top.sv
`timescale 1ns/1ps
module voltage_adc_sequencer_tb_top;
  import adc_seq_pkg::*;
  localparam int CONV = 8;
  localparam int TMO = 50;
  typedef struct {
    logic w;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } row_t;
  row_t rows [16] = '{
    '{0, 8'h21, 8'h00, 8'h00}, '{0, 8'h22, 8'h00, 8'h00},
    '{0, 8'h40, 8'h00, 8'h00}, '{0, 8'h46, 8'h00, 8'h00},
    '{0, 8'h47, 8'h00, 8'hFF}, '{0, 8'h55, 8'h00, 8'h00},
    '{0, 8'h73, 8'h00, 8'h00}, '{0, 8'h10, 8'h00, 8'h00},
    '{1, 8'h46, 8'h5A, 8'h5A}, '{1, 8'h47, 8'hA5, 8'hA5},
    '{1, 8'h21, 8'h77, 8'h00}, '{1, 8'h22, 8'h77, 8'h00},
    '{1, 8'h10, 8'h33, 8'h00}, '{1, 8'h55, 8'h20, 8'h20},
    '{1, 8'h47, 8'hFF, 8'hFF}, '{1, 8'h46, 8'h00, 8'h00}};
  logic [2:0] chans [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic act = 1'b0;
  logic clr = 1'b0;
  logic alert_en = 1'b0;
  logic [9:0] cs_code = 10'h000;
  logic [9:0] own_code = 10'h000;
  logic [7:0] rdata;
  logic [7:0] r;
  logic [9:0] code;
  logic release_p;
  logic start;
  adc_chan_t chan;
  logic bypass;
  logic low_st;
  logic high_st;
  logic alert_n;
  int miscompares = 0;
  int num_checks = 0;
  int n;
  int m;

  voltage_adc_sequencer #(.CONV_CYCLES(CONV), .TIMEOUT_CYCLES(TMO)) i_dut (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .smb_activity_in(act),
    .bus_release_out(release_p), .adc_code_in(code),
    .adc_start_out(start), .adc_chan_out(chan),
    .atten_bypass_out(bypass), .status_clear_in(clr),
    .alert_enable_in(alert_en), .low_status_out(low_st),
    .high_status_out(high_st), .smb_alert_n_out(alert_n));

  adc_conv_model #(.CONV_CYCLES(CONV)) i_conv (
    .ref_clk_in(ref_clk_in), .start_in(start), .chan_in(chan),
    .cs_code_in(cs_code), .own_code_in(own_code), .code_out(code));

  always #12.5 ref_clk_in = ~ref_clk_in;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge ref_clk_in);
    wr = 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_in);
    addr = a;
    rd = 1'b1;
    @(negedge ref_clk_in);
    rd = 1'b0;
    d = rdata;
  endtask

  task automatic conv(input int k);
    repeat (k * CONV) @(negedge ref_clk_in);
  endtask

  task automatic clear_status;
    @(negedge ref_clk_in);
    clr = 1'b1;
    @(negedge ref_clk_in);
    clr = 1'b0;
  endtask

  task automatic test_done;
    if (miscompares == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #(25 * 20000);
    miscompares++;
    test_done();
  end

  initial begin
    repeat (10) @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    check({high_st, low_st, alert_n}, 8'h01);
    check({7'h00, bypass}, 8'h00);
    foreach (rows[i]) begin
      if (rows[i].w) wreg(rows[i].a, rows[i].d);
      rreg(rows[i].a, r);
      check(r, rows[i].e);
    end
    cs_code = 10'h300;
    own_code = 10'h3FF;
    alert_en = 1'b1;
    wreg(8'h47, 8'hC0);
    wreg(8'h73, 8'h50);
    conv(3);
    rreg(8'h21, r);
    check(r, 8'hC0);
    // Equal to the limit is not a violation
    check({high_st, low_st, alert_n}, 8'h01);
    while (start !== 1'b1) @(negedge ref_clk_in);
    n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (start !== 1'b1 && n < 100);
    check(8'(n), 8'(CONV));
    wreg(8'h47, 8'hBF);
    conv(2);
    check({high_st, low_st, alert_n}, 8'h04);
    alert_en = 1'b0;
    wreg(8'h47, 8'hFF);
    clear_status();
    conv(2);
    check({high_st, low_st, alert_n}, 8'h01);
    wreg(8'h46, 8'hC1);
    conv(2);
    // Alert stays quiet while gated off
    check({high_st, low_st, alert_n}, 8'h03);
    wreg(8'h46, 8'h00);
    clear_status();
    foreach (chans[i]) begin
      wreg(8'h55, {chans[i], 5'h00});
      conv(2);
      check({5'h00, chan}, {5'h00, chans[i]});
    end
    rreg(8'h22, r);
    check(r, 8'hFF);
    wreg(8'h55, 8'h20);
    wreg(8'h73, 8'h60);
    cs_code = 10'h000;
    conv(40);
    check({7'h00, bypass}, 8'h01);
    cs_code = 10'h3FC;
    conv(3);
    rreg(8'h21, r);
    // Three samples cannot reach the full value
    check({7'h00, r > 8'h2F}, 8'h00);
    conv(40);
    rreg(8'h21, r);
    check(r, 8'hFF);
    @(negedge ref_clk_in);
    act = 1'b1;
    @(negedge ref_clk_in);
    act = 1'b0;
    n = 0;
    while (release_p !== 1'b1 && n < 200) begin
      @(negedge ref_clk_in);
      n++;
    end
    check(8'(n), 8'(TMO));
    wreg(8'h40, 8'h40);
    n = 0;
    repeat (3 * TMO) begin
      @(negedge ref_clk_in);
      if (release_p !== 1'b0) n++;
    end
    check(8'(n), 8'h00);
    // Cycling mode, averaging off: channel steps after every result
    wreg(8'h73, 8'h10);
    conv(2);
    repeat (5) begin
      while (start !== 1'b1) @(negedge ref_clk_in);
      m = 0;
      foreach (chans[i]) if (chans[i] == chan) m = (i + 1) % 5;
      @(negedge ref_clk_in);
      while (start !== 1'b1) @(negedge ref_clk_in);
      check({5'h00, chan}, {5'h00, chans[m]});
    end
    // Reset in mid-run brings the defaults back
    @(negedge ref_clk_in);
    sys_rst_in = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    check({6'h00, start, alert_n}, 8'h01);
    rreg(8'h21, r);
    check(r, 8'h00);
    rreg(8'h73, r);
    check(r, 8'h00);
    rreg(8'h47, r);
    check(r, 8'hFF);
    test_done();
  end
endmodule
